// >>> logic/spiee_dev.sv
// Device end: serial EEPROM core
// What this block does
// - Mode 0: sample rising, shift falling
// - Four wires, active while select low
// - Array of 2048 eight-bit bytes
// - Reads stream, address auto-increments
// - Page of 1..16 bytes, one cycle
// - Self-timed programming within 10 ms
// - Status shows busy; master polls it
// - Enable/disable opcodes gate programming
// - Two-bit code protects array region
// - Write-protect low blocks all programming
// - Hold pauses transfer, keeps position
// - Master raises select between instructions
`timescale 1ns/10ps
module spiee_dev
  import spiee_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  spiee_if.dev link,
  output logic busy,
  output logic [1:0] protect_code
);
  // ==========================================================
  // State
  typedef enum logic [3:0] {
    ST_OP = 4'b0001, ST_ADDR = 4'b0010, ST_DATA = 4'b0100,
    ST_IGN = 4'b1000
  } spiee_st_t;
  typedef struct packed {
    logic [1:0] cs_s, sck_s, mosi_s, wp_s, hold_s;
    logic sck_prev;
    spiee_st_t st;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic [7:0] op;
    logic [3:0] addr_bits;
    logic [ADDR_W-1:0] addr;
    logic [7:0] tx;
    logic so;
    logic so_en;
    logic wel;
    logic [1:0] bp;
    logic [PAGE_W:0] pcnt;
    logic [ADDR_W-1:0] pbase;
    logic [23:0] ptmr;
    logic bsy;
  } spiee_dev_t;
  spiee_dev_t q, d;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] page [PAGE_BYTES];
  logic sck_r, sck_f, sel, hold, last_bit;
  logic [7:0] in_byte;
  logic wr_page;
  logic [PAGE_W-1:0] pidx;
  logic blocked;
  logic [1:0] blk;

  // Two flops on every pin before use
  assign sel = ~q.cs_s[1];
  assign hold = ~q.hold_s[1];
  assign sck_r = q.sck_s[1] & ~q.sck_prev;
  assign sck_f = ~q.sck_s[1] & q.sck_prev;
  assign last_bit = (q.bitc == 3'h7);
  assign in_byte = {q.sh[6:0], q.mosi_s[1]};
  assign pidx = q.addr[PAGE_W-1:0];
  assign blk = q.pbase[ADDR_W-1 -: 2];
  // Upper quarter, half, or all, per protect code
  always_comb
  begin
    case (q.bp)
      2'h1: blocked = (blk == 2'h3);
      2'h2: blocked = blk[1];
      2'h3: blocked = 1'b1;
      default: blocked = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    d = q;
    wr_page = 1'b0;
    d.cs_s = {q.cs_s[0], link.cs_n};
    d.sck_s = {q.sck_s[0], link.sck};
    d.mosi_s = {q.mosi_s[0], link.mosi};
    d.wp_s = {q.wp_s[0], link.wp_n};
    d.hold_s = {q.hold_s[0], link.hold_n};
    d.sck_prev = q.sck_s[1];
    // Self-timed program cycle, no link clocks needed
    if (q.bsy)
    begin
      if (q.ptmr == 24'(PROG_CYCLES - 1))
        d.bsy = 1'b0;
      else
        d.ptmr = q.ptmr + 24'h1;
    end
    if (!sel)
    begin
      d.st = ST_OP;
      d.bitc = 3'h0;
      d.so_en = 1'b0;
      d.addr_bits = 4'h0;
      // Page commits once select rises after data
      if (q.st == ST_DATA && q.op == OP_WRITE && q.pcnt != '0)
      begin
        d.st = ST_IGN;
        if (q.wp_s[1] && !blocked && !q.bsy)
        begin
          d.bsy = 1'b1;
          d.ptmr = 24'h0;
          d.wel = 1'b0;
        end
        d.pcnt = '0;
      end
      if (q.st == ST_IGN)
        d.st = ST_OP;
    end
    else if (!hold)
    begin
      if (sck_r)
      begin
        d.sh = in_byte;
        d.bitc = q.bitc + 3'h1;
        if (last_bit)
        begin
          case (q.st)
            ST_OP:
            begin
              d.op = in_byte;
              d.st = ST_IGN;
              if (in_byte == OP_RDSR)
              begin
                d.st = ST_DATA;
                d.tx = {4'h0, q.bp, q.wel, q.bsy};
              end
              else if (!q.bsy)
              begin
                if (in_byte == OP_WREN)
                  d.wel = 1'b1;
                else if (in_byte == OP_WRDI)
                  d.wel = 1'b0;
                else if (in_byte == OP_WRSR && q.wel && q.wp_s[1])
                  d.st = ST_DATA;
                else if (in_byte == OP_READ)
                  d.st = ST_ADDR;
                else if (in_byte == OP_WRITE && q.wel)
                  d.st = ST_ADDR;
              end
            end
            ST_ADDR:
            begin
              d.addr_bits = q.addr_bits + 4'h1;
              // First byte gives the top bits; shifter is reused after
              if (q.addr_bits == 4'h0)
                d.addr = {in_byte[2:0], 8'h00};
              else
              begin
                d.addr = {q.addr[ADDR_W-1:8], in_byte};
                d.pbase = {q.addr[ADDR_W-1:8], in_byte};
                d.st = ST_DATA;
                d.tx = mem[{q.addr[ADDR_W-1:8], in_byte}];
              end
            end
            ST_DATA:
            begin
              if (q.op == OP_WRSR)
              begin
                d.bp = in_byte[SR_BP_LO +: 2];
                d.wel = 1'b0;
                d.st = ST_IGN;
              end
              else if (q.op == OP_WRITE)
              begin
                wr_page = 1'b1;
                if (q.pcnt != 5'(PAGE_BYTES))
                  d.pcnt = q.pcnt + 5'h1;
                // Wrap inside the page like common parts do
                d.addr = {q.addr[ADDR_W-1:PAGE_W], pidx + 4'h1};
              end
              else if (q.op == OP_READ)
              begin
                d.addr = q.addr + 11'h1;
                d.tx = mem[q.addr + 11'h1];
              end
              else
                d.tx = {4'h0, q.bp, q.wel, q.bsy};
            end
            default: ;
          endcase
        end
      end
      // Output bit changes on falling edge
      if (sck_f && q.st == ST_DATA && q.op != OP_WRITE
          && q.op != OP_WRSR)
      begin
        d.so_en = 1'b1;
        d.so = q.tx[3'h7 - q.bitc];
      end
      if (q.st == ST_OP || q.st == ST_ADDR)
        d.so_en = 1'b0;
    end
  end

  // ==========================================================
  // Registers; page writes land at commit time
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.cs_s <= 2'h3;
      q.hold_s <= 2'h3;
      q.wp_s <= 2'h3;
      q.st <= ST_OP;
      q.bp <= BP_RESET;
    end
    else
      q <= d;
  end

  // Page buffer and array; reset stands in for a fresh erased part,
  // so array contents do not survive a logic reset
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < MEM_BYTES; i++)
        mem[i] <= ERASED_BYTE;
    end
    else
    begin
      if (wr_page)
        page[pidx] <= in_byte;
      if (d.bsy && !q.bsy)
        for (int i = 0; i < PAGE_BYTES; i++)
          if (i < q.pcnt || q.pcnt == 5'(PAGE_BYTES))
            mem[{q.pbase[ADDR_W-1:PAGE_W], 4'(q.pbase[3:0] + i)}]
              <= page[4'(q.pbase[3:0] + i)];
    end
  end

  // Hold floats the output as well
  assign link.miso_o = q.so;
  assign link.miso_oe_n = ~(q.so_en & sel & q.hold_s[1]);
  assign busy = q.bsy;
  assign protect_code = q.bp;
endmodule // spiee_dev

// >>> logic/spiee_pkg.sv
// Shared constants for the serial EEPROM link
package spiee_pkg;
  // ==========================================================
  // Array geometry
  localparam int unsigned MEM_BYTES = 2048;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned PAGE_W = 4;
  // Content of a byte that was never programmed
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned PROG_TIME_MS = 10;
  localparam int unsigned PROG_CYCLES = CLK_HZ / 1000 * PROG_TIME_MS;
  localparam int unsigned CSH_TIME_NS = 240;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned CSH_CYCLES = (CSH_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SCK_HALF_CYCLES = 10;
  // ==========================================================
  // Instruction codes (values arbitrary)
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  // ==========================================================
  // Status layout
  localparam int unsigned SR_BUSY = 0;
  localparam int unsigned SR_WEL = 1;
  localparam int unsigned SR_BP_LO = 2;
  localparam logic [1:0] BP_RESET = 2'h0;
endpackage

// >>> logic/spiee_if.sv
// Four-wire serial link between master and EEPROM
`timescale 1ns/10ps
interface spiee_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso;
  logic wp_n;
  logic hold_n;
  // Idle level when nothing drives the data line
  assign miso = miso_oe_n ? 1'b1 : miso_o;
  modport dev (input cs_n, sck, mosi, wp_n, hold_n,
    output miso_o, miso_oe_n);
  modport mst (output cs_n, sck, mosi, wp_n, hold_n, input miso);
endinterface

// >>> logic/spiee_mst.sv
// Master end: byte-oriented SPI mode 0 driver
`timescale 1ns/10ps
module spiee_mst
  import spiee_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  spiee_if.mst link,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  input wire logic last,
  input wire logic pause,
  input wire logic protect_n,
  output logic ready,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic idle
);
  typedef enum logic [2:0] {
    MS_IDLE = 3'b001, MS_XFER = 3'b010, MS_GAP = 3'b100
  } spiee_mst_st_t;
  typedef struct packed {
    spiee_mst_st_t st;
    logic [1:0] miso_s;
    logic [4:0] div;
    logic [3:0] half;
    logic [7:0] sh;
    logic [7:0] rx;
    logic rxv;
    logic sck;
    logic cs_n;
    logic lst;
    logic [3:0] gap;
  } spiee_mst_q_t;
  spiee_mst_q_t q, d;
  logic tick;

  assign tick = (q.div == 5'(SCK_HALF_CYCLES - 1));
  // ==========================================================
  // Sequencer: eight mode-0 clocks per byte
  always_comb
  begin
    d = q;
    d.miso_s = {q.miso_s[0], link.miso};
    d.rxv = 1'b0;
    // Pause restarts the half period so data out settles after release
    d.div = (tick || pause) ? 5'h0 : q.div + 5'h1;
    case (q.st)
      MS_IDLE:
        if (start)
        begin
          d.st = MS_XFER;
          d.cs_n = 1'b0;
          d.sh = tx_byte;
          d.lst = last;
          d.half = 4'h0;
          d.div = 5'h0;
        end
      MS_XFER:
        // Hold freezes clock; device keeps its place
        if (tick && !pause)
        begin
          d.half = q.half + 4'h1;
          d.sck = ~q.sck;
          if (!q.sck)
            d.rx = {q.rx[6:0], q.miso_s[1]};
          else
            d.sh = {q.sh[6:0], 1'b0};
          if (q.half == 4'hf)
          begin
            d.rxv = 1'b1;
            d.rx = q.rx;
            d.sh = tx_byte;
            d.half = 4'h0;
            if (q.lst || !start)
            begin
              d.st = MS_GAP;
              d.gap = 4'h0;
              d.cs_n = 1'b1;
            end
            else
              d.lst = last;
          end
        end
      MS_GAP:
        if (q.gap == 4'(CSH_CYCLES + 2))
          d.st = MS_IDLE;
        else
          d.gap = q.gap + 4'h1;
      default: d.st = MS_IDLE;
    endcase
  end

  // ==========================================================
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.st <= MS_IDLE;
      q.cs_n <= 1'b1;
    end
    else
      q <= d;
  end

  assign link.cs_n = q.cs_n;
  assign link.sck = q.sck;
  assign link.mosi = q.sh[7];
  assign link.hold_n = ~pause;
  assign link.wp_n = protect_n;
  assign ready = (q.st == MS_XFER) && tick && !pause && q.half == 4'hf;
  assign rx_byte = q.rx;
  assign rx_valid = q.rxv;
  assign idle = (q.st == MS_IDLE);
endmodule // spiee_mst

// >>> verification/spiee_assertions.sv
// Link-level checks beside the master/EEPROM interface
`timescale 1ns/10ps
module spiee_assertions (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  input wire logic wp_n,
  input wire logic hold_n,
  input wire logic busy,
  input wire logic idle,
  input wire logic ready,
  input wire logic rx_valid
);
  import spiee_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [17:0] busy_cnt_q;
  // ==========================================================
  // Busy length counter; a stuck busy shows up as a count above PROG_CYCLES
  always_ff @(posedge mclk)
  begin
    busy_cnt_q <= (!rstn || !busy) ? 18'h0 : busy_cnt_q + 18'h1;
  end
  // ==========================================================
  // Properties
  property p_cs_release; cs_n [*5] |-> miso_oe_n; endproperty
  property p_sck_idle; idle |-> cs_n && !sck; endproperty
  property p_sck_high; $rose(sck) |-> sck [*8]; endproperty
  property p_mosi_low; !cs_n && $changed(mosi) |-> !sck; endproperty
  property p_miso_fall;
    !miso_oe_n && $past(!miso_oe_n) && sck && $past(sck)
      |-> $stable(miso_o);
  endproperty
  property p_rx_after; ready |=> rx_valid; endproperty
  property p_prog_len; busy_cnt_q <= PROG_CYCLES; endproperty
  property p_commit_cs; $rose(busy) |-> cs_n && $past(cs_n); endproperty
  property p_commit_wp; $rose(busy) |-> wp_n; endproperty
  property p_cs_gap; $rose(cs_n) |-> cs_n [*5]; endproperty
  a_cs_release: assert property (p_cs_release)
    else $error("data out driven while deselected");
  a_sck_idle: assert property (p_sck_idle)
    else $error("clock not low or select low when idle");
  a_sck_high: assert property (p_sck_high)
    else $error("clock high phase too short");
  a_mosi_low: assert property (p_mosi_low)
    else $error("data in changed while clock high");
  a_miso_fall: assert property (p_miso_fall)
    else $error("data out changed while clock high");
  a_rx_after: assert property (p_rx_after)
    else $error("received byte not flagged after ready");
  a_prog_len: assert property (p_prog_len)
    else $error("programming cycle too long");
  a_commit_cs: assert property (p_commit_cs)
    else $error("commit started inside a frame");
  a_commit_wp: assert property (p_commit_wp)
    else $error("commit started with write protect low");
  a_cs_gap: assert property (p_cs_gap)
    else $error("select high time too short");
  c_busy: cover property ($rose(busy));
  c_hold: cover property (!hold_n && !cs_n);
  c_drive: cover property ($fell(miso_oe_n));
endmodule // spiee_assertions

// >>> verification/spiee_tb.sv
// Self-checking bench for the master and EEPROM ends
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module spiee_tb;
  import spiee_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic last = 1'b0;
  logic pause = 1'b0;
  logic protect_n = 1'b1;
  logic [7:0] tx_byte = 8'h00;
  logic ready, rx_valid, idle, busy;
  logic [1:0] protect_code;
  logic [7:0] rx_byte;
  logic [7:0] tx_buf [0:19];
  logic [7:0] rx_buf [0:19];
  logic [7:0] a [0:3];
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  spiee_if link ();
  spiee_dev spiee_dev_inst (.mclk(mclk), .rstn(rstn), .link(link.dev),
    .busy(busy), .protect_code(protect_code));
  spiee_mst spiee_mst_inst (.mclk(mclk), .rstn(rstn), .link(link.mst),
    .start(start), .tx_byte(tx_byte), .last(last), .pause(pause),
    .protect_n(protect_n), .ready(ready), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .idle(idle));
  spiee_assertions spiee_assertions_inst (.mclk(mclk), .rstn(rstn),
    .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi),
    .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n), .wp_n(link.wp_n),
    .hold_n(link.hold_n), .busy(busy), .idle(idle), .ready(ready),
    .rx_valid(rx_valid));
  // 50 ns clock
  always #25 mclk = ~mclk;
  // ==========================================================
  // Hang guard; whole plan needs roughly 16k cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One framed transfer of n bytes; pause held after byte ph
  task automatic frame(input int n, input int ph);
    int i, k;
    @(posedge mclk);
    start <= 1'b1;
    tx_byte <= tx_buf[0];
    last <= (n == 1);
    // Idle master takes byte 0 here; later bytes go at ready
    @(posedge mclk);
    for (i = 0; i < n; i++)
    begin
      // Next byte must already stand at this byte's ready edge
      if (i + 1 < n)
      begin
        tx_byte <= tx_buf[i + 1];
        last <= (i + 2 == n);
      end
      else start <= 1'b0;
      k = 0;
      @(posedge mclk);
      while (ready !== 1'b1 && k < 2000)
      begin
        @(posedge mclk);
        k++;
      end
      @(posedge mclk);
      `CHK(rx_valid, 1'b1)
      rx_buf[i] = rx_byte;
      // Pause a cycle after the clock fall so that edge is not lost
      if (i == ph)
      begin
        pause <= 1'b1;
        repeat (200) @(posedge mclk);
        pause <= 1'b0;
      end
    end
    k = 0;
    while (idle !== 1'b1 && k < 2000)
    begin
      @(posedge mclk);
      k++;
    end
    repeat (CSH_CYCLES + 3) @(posedge mclk);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] arg, int n);
    tx_buf[0] = op;
    tx_buf[1] = arg;
    frame(n, 99);
  endtask
  // Status read, compared under a mask
  task automatic status(input logic [7:0] m, input logic [7:0] e);
    cmd(OP_RDSR, 8'h00, 2);
    `CHK(rx_buf[1] & m, e)
  endtask
  // Array access: opcode, two address bytes, n data bytes
  task automatic acc(input logic [7:0] op, input logic [10:0] ad,
    input int n, input int ph);
    int i;
    tx_buf[0] = op;
    tx_buf[1] = {5'h00, ad[10:8]};
    tx_buf[2] = ad[7:0];
    for (i = 0; i < n; i++) tx_buf[3 + i] = 8'h40 + 8'(i);
    frame(3 + n, ph);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    `CHK(busy, 1'b0)
    `CHK(protect_code, 2'h0)
    `CHK(link.cs_n, 1'b1)
    `CHK(link.sck, 1'b0)
    `CHK(link.miso, 1'b1)
  endtask
  task automatic t_enable();
    status(8'hff, 8'h00);
    cmd(OP_WREN, 8'h00, 1);
    status(8'hff, 8'h02);
    cmd(OP_WRDI, 8'h00, 1);
    status(8'hff, 8'h00);
  endtask
  task automatic t_refused();
    acc(OP_WRITE, 11'h000, 4, 99);
    `CHK(busy, 1'b0)
    protect_n <= 1'b0;
    cmd(OP_WREN, 8'h00, 1);
    acc(OP_WRITE, 11'h000, 4, 99);
    `CHK(busy, 1'b0)
    protect_n <= 1'b1;
  endtask
  task automatic t_read();
    acc(OP_READ, 11'h000, 4, 99);
    for (int i = 0; i < 4; i++) a[i] = rx_buf[3 + i];
    `CHK(rx_buf[6], ERASED_BYTE)
    acc(OP_READ, 11'h002, 2, 99);
    `CHK(rx_buf[3], a[2])
    `CHK(rx_buf[4], a[3])
    acc(OP_READ, 11'h001, 2, 3);
    `CHK(rx_buf[3], a[1])
    `CHK(rx_buf[4], a[2])
  endtask
  task automatic t_protect();
    cmd(OP_WREN, 8'h00, 1);
    cmd(OP_WRSR, 8'h0c, 2);
    `CHK(protect_code, 2'h3)
    status(8'h0d, 8'h0c);
    cmd(OP_WREN, 8'h00, 1);
    acc(OP_WRITE, 11'h000, 1, 99);
    `CHK(busy, 1'b0)
    cmd(OP_WREN, 8'h00, 1);
    cmd(OP_WRSR, 8'h00, 2);
    `CHK(protect_code, 2'h0)
  endtask
  // Codes 1 and 2, then a full page below the top half;
  // busy then blocks reads of that freshly written page
  task automatic t_commit();
    cmd(OP_WREN, 8'h00, 1);
    cmd(OP_WRSR, 8'h04, 2);
    `CHK(protect_code, 2'h1)
    cmd(OP_WREN, 8'h00, 1);
    acc(OP_WRITE, 11'h7f0, 1, 99);
    `CHK(busy, 1'b0)
    cmd(OP_WREN, 8'h00, 1);
    cmd(OP_WRSR, 8'h08, 2);
    `CHK(protect_code, 2'h2)
    cmd(OP_WREN, 8'h00, 1);
    acc(OP_WRITE, 11'h400, 1, 99);
    `CHK(busy, 1'b0)
    cmd(OP_WREN, 8'h00, 1);
    acc(OP_WRITE, 11'h3f0, 16, 99);
    `CHK(busy, 1'b1)
    status(8'h01, 8'h01);
    acc(OP_READ, 11'h3f0, 1, 99);
    `CHK(rx_buf[3], 8'hff)
    `CHK(busy, 1'b1)
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    t_reset();
    t_enable();
    t_refused();
    t_read();
    t_protect();
    t_commit();
    summarize();
  end
endmodule // spiee_tb
